// *** sbtc_defs.vh ***
`ifndef SBTC_DEFS_VH
`define SBTC_DEFS_VH

// ==============================
// register addresses (byte wide port)
`define SBTC_ADDR_W        8
`define SBTC_ADDR_FLAG     8'h0c
`define SBTC_ADDR_ENABLE   8'h8c
`define SBTC_ADDR_CNT_LO   8'h0e
`define SBTC_ADDR_CNT_HI   8'h0f
`define SBTC_ADDR_CTRL     8'h10

// ==============================
// counter_control fields
`define SBTC_CTRL_RESET    6'h00
`define SBTC_CTRL_RUN      0
`define SBTC_CTRL_CS       1
`define SBTC_CTRL_BYPASS   2
`define SBTC_CTRL_OSCEN    3
`define SBTC_CTRL_PS_LO    4
`define SBTC_CTRL_PS_HI    5

// flag / enable registers: overflow at bit 0
`define SBTC_OVF_BIT       0

// compare special event trigger mode code
`define SBTC_MODE_SPECIAL  4'hb

// value a special event trigger loads into the count
`define SBTC_COUNT_CLEAR   16'h0000

// internal clock divider: Fosc/4 with ref_clk as Fosc
`define SBTC_FOSC_DIV      2'h3

// oscillator rating
`define SBTC_OSC_MAX_KHZ   200

`endif

// *** sbtc_timer.v ***
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "sbtc_defs.vh"

// How it works
// - bypass mode: counts async, overflow wakes sleep
// - no capture/compare base in async mode
// - count byte reads always valid
// - oscillator enable runs oscillator, also sleep
// - special mode trigger clears the count
// - trigger clear never sets overflow flag
// - trigger clear needs timer or synced mode
// - count write beats simultaneous trigger
// - resets leave count bytes unchanged
// - control clears only on power/brown-out reset
// - count byte write clears prescaler
// - overflow flag/enable bit 0, 0ch/8ch
// - count up, wrap, latch overflow flag
// - two-bit prescale: 1,2,4,8
// - source select: fosc/4 or external edges
// - synced mode: no increments in sleep
module sbtc_timer #(
  parameter PS_W = 3
) (
  ref_clk,
  reset,
  por_reset,
  clk_en,
  sleep,
  ext_count_clock_pin,
  osc_input_pin,
  cmp1_mode,
  cmp1_trigger,
  cmp2_mode,
  cmp2_trigger,
  bus_addr,
  bus_wdata,
  bus_wr,
  bus_rd,
  bus_rdata,
  osc_output_pin,
  osc_running,
  overflow_irq,
  wake_req
);
  // ==============================
  // ports
  // clock, resets and core state
  input  wire       ref_clk;
  input  wire       reset;
  input  wire       por_reset;
  input  wire       clk_en;
  input  wire       sleep;

  // count sources, both outside the clock domain
  input  wire       ext_count_clock_pin;
  input  wire       osc_input_pin;

  // compare unit modes and trigger pulses
  input  wire [3:0] cmp1_mode;
  input  wire       cmp1_trigger;
  input  wire [3:0] cmp2_mode;
  input  wire       cmp2_trigger;

  // register port
  input  wire [7:0] bus_addr;
  input  wire [7:0] bus_wdata;
  input  wire       bus_wr;
  input  wire       bus_rd;
  output reg  [7:0] bus_rdata;

  // pins and status
  output reg        osc_output_pin;
  output reg        osc_running;
  output reg        overflow_irq;
  output reg        wake_req;

  // ==============================
  // notes for users
  // - the count bytes power up unknown; write them before relying on them
  // - async counting runs on ref_clk here: it keeps counting in sleep and
  //   ignores the compare trigger, which real async hardware may miss
  // - the two count bytes are read one at a time, so software must allow
  //   for a carry between the two reads
  // - the oscillator start-up delay is the software's job; the count only
  //   sees edges once the input swings
  // - a write beside an increment keeps the written byte, drops the step
  // - a wrap in the same cycle as a flag clear leaves the flag set
  // - only bit 0 of the flag and enable registers exists; the rest read 0
  // - irq and wake follow the flag one cycle late, or a wrap of this cycle
  // - clk_en low freezes every register, resets excepted

  // ==============================
  // registers
  reg [15:0]     count_reg;
  reg [5:0]      ctrl_reg;
  reg            ovf_flag_reg;
  reg            ovf_en_reg;
  reg [PS_W-1:0] ps_cnt_reg;
  reg [1:0]      fosc_div_reg;
  reg [2:0]      ext_sync_reg;
  reg [2:0]      osc_sync_reg;
  reg            ext_armed_reg;
  reg            ps_out_q_reg;

  // next-state values, settled by the combinational blocks below
  reg [15:0]     count_next;
  reg [5:0]      ctrl_next;
  reg            ovf_flag_next;
  reg            ovf_en_next;
  reg [PS_W-1:0] ps_cnt_next;
  reg            ext_armed_next;
  reg [7:0]      rdata_next;
  reg            osc_out_next;
  reg            irq_next;
  reg            wake_next;

  wire       run     = ctrl_reg[`SBTC_CTRL_RUN];
  wire       ext_sel = ctrl_reg[`SBTC_CTRL_CS];
  wire       bypass  = ctrl_reg[`SBTC_CTRL_BYPASS];
  wire       osc_en  = ctrl_reg[`SBTC_CTRL_OSCEN];
  wire [1:0] ps_sel  = ctrl_reg[`SBTC_CTRL_PS_HI:`SBTC_CTRL_PS_LO];

  // ==============================
  // mode decode
  // three ways to count; exactly one is live while the run bit is set
  wire mode_timer = ~ext_sel;
  wire mode_sync  = ext_sel & ~bypass;
  wire mode_async = ext_sel & bypass;

  // ==============================
  // helpers
  function [PS_W-1:0] sbtc_ps_mask;
    input [1:0] sel;
    begin
      // sel ones in the low bits: 0, 1, 3, 7 for the four ratios
      sbtc_ps_mask = ~({PS_W{1'b1}} << sel);
    end
  endfunction

  function sbtc_is_special;
    input [3:0] mode;
    begin
      sbtc_is_special = (mode == `SBTC_MODE_SPECIAL);
    end
  endfunction

  // ==============================
  // external edge detection
  // pin and oscillator are outside the clock domain: two flops before use,
  // the third stage only feeds the edge detector
  wire ext_s  = ext_sync_reg[1];
  // the oscillator input is dead while the oscillator is off
  wire osc_s  = osc_sync_reg[1] & osc_en;
  wire src_lv = osc_en ? osc_s : ext_s;
  wire src_pv = osc_en ? (osc_sync_reg[2] & osc_en) : ext_sync_reg[2];
  wire rise   = src_lv & ~src_pv;
  wire fall   = ~src_lv & src_pv;

  // pin-to-count latency: two synchroniser stages and the edge detector
  // put an external rise three ref_clk cycles late; synced mode adds one
  // more flop. pulses shorter than one ref_clk cycle may be lost.

  // internal source is one tick every fourth ref_clk
  wire int_tick = (fosc_div_reg == `SBTC_FOSC_DIV);
  // the counter only advances after a falling edge has been seen once enabled
  wire ext_tick = rise & ext_armed_reg;
  wire src_tick = ext_sel ? ext_tick : int_tick;

  // prescaler keeps running in sleep in synced mode; only the count stalls
  wire ps_hit = ((ps_cnt_reg & sbtc_ps_mask(ps_sel)) == sbtc_ps_mask(ps_sel));
  wire ps_out = run & src_tick & ps_hit;

  // async mode: no sync stage, counts in sleep; synced mode adds one flop
  // and is blocked by sleep; timer mode stops in sleep with the core clock
  wire inc_async = mode_async & ps_out;
  wire inc_sync  = mode_sync & ps_out_q_reg & ~sleep;
  wire inc_timer = mode_timer & ps_out & ~sleep;
  wire inc       = run & (inc_async | inc_sync | inc_timer);

  // a trigger from either unit in special event mode
  wire trig_req = (cmp1_trigger & sbtc_is_special(cmp1_mode)) |
                  (cmp2_trigger & sbtc_is_special(cmp2_mode));
  // trigger clear honoured only outside async counting; async may miss it
  wire trig = trig_req & ~mode_async;

  wire wr_lo   = bus_wr & (bus_addr == `SBTC_ADDR_CNT_LO);
  wire wr_hi   = bus_wr & (bus_addr == `SBTC_ADDR_CNT_HI);
  wire wr_cnt  = wr_lo | wr_hi;
  wire wr_ctrl = bus_wr & (bus_addr == `SBTC_ADDR_CTRL);
  wire wr_flag = bus_wr & (bus_addr == `SBTC_ADDR_FLAG);
  wire wr_en   = bus_wr & (bus_addr == `SBTC_ADDR_ENABLE);

  wire [16:0] sum  = {1'b0, count_reg} + 17'h00001;
  wire        wrap = inc & sum[16] & ~trig & ~wr_cnt;

  // ==============================
  // counter; count bytes take no reset value
  // a write wins over a trigger, a trigger over an increment; software
  // should stop the counter first, since a write beside an increment
  // loses that increment
  always @* begin
    count_next = count_reg;
    if (wr_cnt) begin
      if (wr_lo)
        count_next[7:0] = bus_wdata;
      if (wr_hi)
        count_next[15:8] = bus_wdata;
    end else if (trig) begin
      count_next = `SBTC_COUNT_CLEAR;
    end else if (inc) begin
      count_next = sum[15:0];
    end
  end

  // no reset branch on purpose: every reset leaves the count alone
  always @(posedge ref_clk) begin
    if (clk_en)
      count_reg <= count_next;
  end

  // ==============================
  // pin synchronisers
  // raw pins land in stage 0 only; gating by the enable bits happens after
  // stage 1, so no logic ever looks at a pin that may be metastable
  always @(posedge ref_clk) begin
    if (reset) begin
      ext_sync_reg <= 3'h0;
      osc_sync_reg <= 3'h0;
    end else if (clk_en) begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_count_clock_pin};
      osc_sync_reg <= {osc_sync_reg[1:0], osc_input_pin};
    end
  end

  // ==============================
  // prescaler, divider and edge logic
  // a count byte write restarts the prescaler, so the next increment is a
  // full ratio away from the write
  always @* begin
    ext_armed_next = ext_armed_reg;
    if (!run || !ext_sel)
      ext_armed_next = 1'b0;
    else if (fall)
      ext_armed_next = 1'b1;
    ps_cnt_next = ps_cnt_reg;
    if (wr_cnt)
      ps_cnt_next = {PS_W{1'b0}};
    else if (run && src_tick)
      ps_cnt_next = ps_hit ? {PS_W{1'b0}} : ps_cnt_reg + {{(PS_W-1){1'b0}}, 1'b1};
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      ps_cnt_reg    <= {PS_W{1'b0}};
      fosc_div_reg  <= 2'h0;
      ext_armed_reg <= 1'b0;
      ps_out_q_reg  <= 1'b0;
    end else if (clk_en) begin
      fosc_div_reg  <= fosc_div_reg + 2'h1;
      ps_out_q_reg  <= ps_out;
      ext_armed_reg <= ext_armed_next;
      ps_cnt_reg    <= ps_cnt_next;
    end
  end

  // ==============================
  // control, flag and enable registers
  always @* begin
    ctrl_next     = ctrl_reg;
    ovf_en_next   = ovf_en_reg;
    ovf_flag_next = ovf_flag_reg;
    if (wr_ctrl)
      ctrl_next = bus_wdata[`SBTC_CTRL_PS_HI:0];
    if (wr_en)
      ovf_en_next = bus_wdata[`SBTC_OVF_BIT];
    // overflow sets win over a software clear in the same cycle
    if (wrap)
      ovf_flag_next = 1'b1;
    else if (wr_flag)
      ovf_flag_next = bus_wdata[`SBTC_OVF_BIT];
  end

  // only a power-on or brown-out reset touches the control bits
  always @(posedge ref_clk) begin
    if (por_reset) begin
      ctrl_reg     <= `SBTC_CTRL_RESET;
      ovf_flag_reg <= 1'b0;
      ovf_en_reg   <= 1'b0;
    end else if (reset) begin
      ovf_flag_reg <= 1'b0;
      ovf_en_reg   <= 1'b0;
    end else if (clk_en) begin
      ctrl_reg     <= ctrl_next;
      ovf_flag_reg <= ovf_flag_next;
      ovf_en_reg   <= ovf_en_next;
    end
  end

  // ==============================
  // read port and outputs
  // reads sample the internal count, which is already in this domain, so a
  // byte read is never torn; the two bytes are not latched together
  always @* begin
    rdata_next = 8'h00;
    if (bus_rd) begin
      if (bus_addr == `SBTC_ADDR_CNT_LO)
        rdata_next = count_reg[7:0];
      else if (bus_addr == `SBTC_ADDR_CNT_HI)
        rdata_next = count_reg[15:8];
      else if (bus_addr == `SBTC_ADDR_CTRL)
        rdata_next = {2'h0, ctrl_reg};
      else if (bus_addr == `SBTC_ADDR_FLAG)
        rdata_next = {7'h00, ovf_flag_reg};
      else if (bus_addr == `SBTC_ADDR_ENABLE)
        rdata_next = {7'h00, ovf_en_reg};
      else
        rdata_next = 8'h00;
    end
  end

  // amplifier output mirrors the inverted input while enabled; irq and
  // wake also see a wrap of this cycle so they do not lag the flag
  always @* begin
    osc_out_next = osc_en & ~osc_sync_reg[1];
    irq_next     = (ovf_flag_reg | wrap) & ovf_en_reg;
    wake_next    = irq_next & sleep;
  end

  always @(posedge ref_clk) begin
    if (reset || por_reset) begin
      bus_rdata      <= 8'h00;
      osc_output_pin <= 1'b0;
      osc_running    <= 1'b0;
      overflow_irq   <= 1'b0;
      wake_req       <= 1'b0;
    end else if (clk_en) begin
      bus_rdata      <= rdata_next;
      osc_output_pin <= osc_out_next;
      osc_running    <= osc_en;
      overflow_irq   <= irq_next;
      wake_req       <= wake_next;
    end
  end

endmodule

// *** sbtc_timer_sva.sv ***
`timescale 1ns/1ps
module sbtc_timer_sva (
  input wire       ref_clk,
  input wire       reset,
  input wire       por_reset,
  input wire       sleep,
  input wire [7:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire       bus_wr,
  input wire       bus_rd,
  input wire [7:0] bus_rdata,
  input wire       osc_output_pin,
  input wire       osc_running,
  input wire       overflow_irq,
  input wire       wake_req
);
  // ==============================
  // register port
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset || por_reset);
  sequence s_ctrl_wr_rd;
    bus_wr && bus_addr == 8'h10 ##1 bus_rd && bus_addr == 8'h10;
  endsequence
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("rdata not idle");
  a_ctrl_back: assert property (s_ctrl_wr_rd |=> bus_rdata == ($past(bus_wdata, 2) & 8'h3f))
    else $error("ctrl readback");
  a_ctrl_top: assert property ($past(bus_rd && bus_addr == 8'h10) |-> !bus_rdata[7:6])
    else $error("ctrl top bits");
  a_no_decode: assert property ($past(bus_rd && bus_addr == 8'h20) |-> bus_rdata == 8'h00)
    else $error("unmapped read");
  a_irq_masked: assert property (bus_wr && bus_addr == 8'h8c && !bus_wdata[0] |-> ##2 !overflow_irq)
    else $error("irq while masked");
  // ==============================
  // wake and oscillator pins
  a_wake_sleep: assert property (wake_req |-> $past(sleep))
    else $error("wake while awake");
  a_wake_irq: assert property (wake_req |-> overflow_irq)
    else $error("wake without irq");
  a_osc_quiet: assert property (!osc_running |-> !osc_output_pin)
    else $error("osc pin while off");
endmodule

// *** sbtc_clk_model.sv ***
`timescale 1ns/1ps
module sbtc_clk_model #(
  parameter HALF = 40
) (
  input  wire osc_running,
  input  wire ext_go,
  output reg  osc_input_pin,
  output reg  ext_count_clock_pin
);
  // ==============================
  // both clocks rest low when idle, so the first event of a burst is a rise
  initial osc_input_pin = 1'b0;
  initial ext_count_clock_pin = 1'b0;
  always #(HALF) osc_input_pin = osc_running ? ~osc_input_pin : 1'b0;
  always #(HALF) ext_count_clock_pin = ext_go ? ~ext_count_clock_pin : 1'b0;
endmodule

// *** sbtc_timer_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t %h %h", $time, (a), (e)); end end
module sbtc_timer_tb_top;
  logic        ref_clk, reset, por_reset, sleep, ext_go, bus_wr, bus_rd;
  logic        cmp1_trigger, cmp2_trigger, ext_count_clock_pin, osc_input_pin;
  logic        osc_output_pin, osc_running, overflow_irq, wake_req;
  logic [3:0]  cmp1_mode, cmp2_mode;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata, d;
  logic [15:0] v;
  int          err_total, checked, cyc, i, e;

  sbtc_timer dut (.ref_clk, .reset, .por_reset, .clk_en(1'b1), .sleep,
    .ext_count_clock_pin, .osc_input_pin, .cmp1_mode, .cmp1_trigger, .cmp2_mode,
    .cmp2_trigger, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .osc_output_pin, .osc_running, .overflow_irq, .wake_req);
  sbtc_clk_model far (.osc_running, .ext_go, .osc_input_pin, .ext_count_clock_pin);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done;
    end
  end
  // ==============================
  // bus tasks: entered just after an edge, leave 1 ns after one
  task wr(input [7:0] a, input [7:0] w);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= w;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task rd(input [7:0] a, output [7:0] q);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 q = bus_rdata;
  endtask
  // no latching: the pair may wrap between the two reads
  task rc(output [15:0] q);
    rd(8'h0e, q[7:0]);
    rd(8'h0f, q[15:8]);
  endtask
  task trig(input bit u);
    if (u) cmp2_trigger <= 1'b1;
    else cmp1_trigger <= 1'b1;
    @(posedge ref_clk);
    {cmp1_trigger, cmp2_trigger} <= 2'b00;
    #1;
  endtask
  task rst(input bit p);
    {reset, por_reset} <= p ? 2'b01 : 2'b10;
    repeat (2) @(posedge ref_clk);
    {reset, por_reset} <= 2'b00;
    @(posedge ref_clk);
    #1;
  endtask
  task test_done;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==============================
  // tests
  initial begin
    {reset, por_reset, sleep, ext_go, bus_wr, bus_rd, cmp1_trigger, cmp2_trigger} = 8'hc0;
    {cmp1_mode, cmp2_mode, bus_addr, bus_wdata} = 24'h000000;
    repeat (2) @(posedge ref_clk);
    {reset, por_reset} <= 2'b00;
    @(posedge ref_clk);
    rd(8'h10, d); `CHK(d, 8'h00)
    rd(8'h8c, d); `CHK(d, 8'h00)
    rd(8'h20, d); `CHK(d, 8'h00)
    wr(8'h10, 8'hf0);
    rd(8'h10, d); `CHK(d, 8'h30)
    wr(8'h0f, 8'haa);
    wr(8'h0e, 8'h55);
    rc(v); `CHK(v, 16'haa55)
    rst(1'b0);
    rc(v); `CHK(v, 16'haa55)
    rd(8'h10, d); `CHK(d, 8'h30)
    rst(1'b1);
    rc(v); `CHK(v, 16'haa55)
    rd(8'h10, d); `CHK(d, 8'h00)
    $display("done registers and resets");
    wr(8'h0f, 8'hff);
    wr(8'h0e, 8'hfd);
    wr(8'h8c, 8'h01);
    wr(8'h10, 8'h01);
    repeat (20) @(posedge ref_clk);
    rd(8'h0c, d); `CHK(d, 8'h01)
    `CHK(overflow_irq, 1'b1)
    wr(8'h0c, 8'h00);
    rd(8'h0c, d); `CHK(d, 8'h00)
    $display("done overflow");
    for (i = 0; i < 4; i++) begin
      {cmp1_mode, cmp2_mode} <= i[1] ? 8'hbb : 8'h00;
      wr(8'h10, 8'h00);
      wr(8'h0f, 8'h80);
      wr(8'h10, 8'h01);
      trig(i[0]);
      rc(v); `CHK(v[15], !i[1])
    end
    rd(8'h0c, d); `CHK(d, 8'h00)
    wr(8'h10, 8'h00);
    cmp1_trigger <= 1'b1;
    wr(8'h0f, 8'h12);
    cmp1_trigger <= 1'b0;
    rd(8'h0f, d); `CHK(d, 8'h12)
    $display("done trigger");
    for (i = 0; i < 4; i++) begin
      wr(8'h10, 8'h00);
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h00);
      wr(8'h10, 8'h01 | 8'(i << 4));
      repeat (128) @(posedge ref_clk);
      wr(8'h10, 8'h00);
      rc(v);
      e = 32 >> i;
      `CHK(v >= e - 1 && v <= e + 1, 1'b1)
    end
    $display("done prescale");
    wr(8'h0f, 8'hff);
    wr(8'h0e, 8'hfc);
    wr(8'h10, 8'h07);
    sleep <= 1'b1;
    ext_go = 1'b1;
    repeat (10) @(posedge ext_count_clock_pin);
    ext_go = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1 `CHK(wake_req, 1'b1)
    rc(v); `CHK(v, 16'h0005)
    wr(8'h10, 8'h03);
    ext_go = 1'b1;
    repeat (4) @(posedge ext_count_clock_pin);
    ext_go = 1'b0;
    repeat (20) @(posedge ref_clk);
    rc(v); `CHK(v, 16'h0005)
    sleep <= 1'b0;
    wr(8'h8c, 8'h00);
    wr(8'h10, 8'h08);
    repeat (50) @(posedge ref_clk);
    #1 `CHK(osc_running, 1'b1)
    @(posedge osc_input_pin);
    repeat (4) @(posedge ref_clk);
    #1 `CHK(osc_output_pin, 1'b0)
    @(negedge osc_input_pin);
    repeat (4) @(posedge ref_clk);
    #1 `CHK(osc_output_pin, 1'b1)
    wr(8'h10, 8'h00);
    repeat (4) @(posedge ref_clk);
    #1 `CHK(osc_output_pin, 1'b0)
    $display("done external clocks");
    test_done;
  end
endmodule

bind sbtc_timer sbtc_timer_sva u_sva (.ref_clk, .reset, .por_reset, .sleep, .bus_addr,
  .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .osc_output_pin, .osc_running,
  .overflow_irq, .wake_req);
